//--- design/psq_positioning_sequencer.v
`timescale 1ns/100ps
// What this block does
// - aux code 1 or 3 chains next table
// - chains of at most seven tables
// - pause halts when step divider reaches STEP_DIV
// - second pause resumes remaining distance
// - starts ignored while paused
// - auto-to-manual while paused clears remainder
// - pause ignored during homing or jog
// - complete flag low during chain
// - start, pause, home and jog inputs delayed by filter time
// - program mode runs selected program on forward start
// - default command system is absolute
// - positions limited to plus/minus 999999
// - eight programs, 120 steps total
// - three select lines give program number
// - speed command sets commanded speed
// - accel/decel commands 0..20000 ms, frozen moving
// - combined command loads both time constants
// - s-curve time 0..100 ms
// - absolute move sets absolute target
// - absolute chain stops at target before next step, like absolute move
// - incremental moves use travel distance
// - speed and time settings persist
`include "psq_defs.vh"
module psq_positioning_sequencer #(
  parameter MAX_SPEED = 16'd3000,
  parameter STEP_DIV = 16'd200
) (
  input wire clock,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire pause_request,
  input wire forward_start,
  input wire reverse_start,
  input wire program_select_0,
  input wire program_select_1,
  input wire program_select_2,
  input wire home_active,
  input wire jog_active,
  input wire auto_mode,
  output reg move_complete_flag,
  output reg in_position_flag,
  output reg motion_active,
  output reg pause_active
);
  localparam ST_IDLE = 3'd0;
  localparam ST_LOAD = 3'd1;
  localparam ST_MOVE = 3'd2;
  localparam ST_DECEL = 3'd3;
  localparam ST_HALT = 3'd4;
  localparam ST_PSTEP = 3'd5;
  reg rs1_r, rst_r;
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rs1_r <= 1'b0;
      rst_r <= 1'b0;
    end
    else
    begin
      rs1_r <= 1'b1;
      rst_r <= rs1_r;
    end
  end
  wire rst_n = rst_r;
  reg [15:0] filt_r;
  wire [4:0] flt, rise;
  wire [4:0] raw = {reverse_start, forward_start, pause_request, jog_active, home_active};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_filt
      reg [15:0] cnt_r;
      reg prev_r, lvl_r, dly_r;
      assign flt[gi] = lvl_r;
      assign rise[gi] = lvl_r & ~dly_r;
      always @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          cnt_r <= 16'h0000;
          lvl_r <= 1'b0;
          dly_r <= 1'b0;
          prev_r <= 1'b0;
        end
        else
        begin
          prev_r <= raw[gi];
          dly_r <= lvl_r;
          if (raw[gi] != prev_r)
            cnt_r <= 16'h0000;
          else if (cnt_r < filt_r)
            cnt_r <= cnt_r + 16'h0001;
          else
            lvl_r <= raw[gi];
        end
      end
    end
  endgenerate
  wire homing = flt[0];
  wire jogging = flt[1];
  wire pause_rise = rise[2];
  wire fwd_rise = rise[3];
  wire rev_rise = rise[4];
  reg signed [23:0] tab_pos [0:7];
  reg [19:0] tab_cfg [0:7];
  reg [31:0] tab_tc [0:7];
  reg [31:0] prg_mem [0:127];
  reg [6:0] prg_start [0:7];
  reg [6:0] prg_len [0:7];
  reg [2:0] ctrl_r;
  reg [2:0] tab_idx_r;
  reg [6:0] prg_wptr_r;
  reg [2:0] prg_wsel_r;
  reg signed [23:0] target_r, cur_r;
  reg [15:0] speed_r, acc_r, dec_r;
  reg [6:0] scurve_r;
  reg [2:0] state_r;
  reg [2:0] cur_tab_r;
  reg [2:0] chain_len_r;
  reg [6:0] pc_r, pend_r;
  reg dir_rev_r;
  reg [15:0] div_r;
  reg prg_err_r;
  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite;
  wire [2:0] prog_sel = {program_select_2, program_select_1, program_select_0};
  wire auto_on = ctrl_r[`PSQ_CTRL_AUTO] & auto_mode;
  wire signed [23:0] remain = target_r - cur_r;
  wire [31:0] op = prg_mem[pc_r];
  wire [23:0] operand = op[23:0];
  wire [15:0] tc_op = (operand[15:0] > `PSQ_TC_MAX) ? `PSQ_TC_MAX : operand[15:0];
  wire [6:0] total_steps = prg_start[prg_wsel_r] + prg_len[prg_wsel_r];
  function signed [23:0] clamp;
    input signed [23:0] v;
    begin
      if (v > `PSQ_POS_MAX)
        clamp = `PSQ_POS_MAX;
      else if (v < -`PSQ_POS_MAX)
        clamp = -`PSQ_POS_MAX;
      else
        clamp = v;
    end
  endfunction
  integer i;
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= 3'h0;
      tab_idx_r <= 3'h1;
      filt_r <= `PSQ_FILT_RESET;
      prg_wptr_r <= 7'h00;
      prg_wsel_r <= 3'h0;
      prg_err_r <= 1'b0;
      for (i = 0; i < 8; i = i + 1)
      begin
        prg_start[i] <= 7'h00;
        prg_len[i] <= 7'h00;
      end
    end
    else if (wr)
    begin
      case (paddr)
        `PSQ_CTRL_OFS: ctrl_r <= pwdata[2:0];
        `PSQ_TAB_IDX_OFS: tab_idx_r <= pwdata[2:0];
        `PSQ_FILT_OFS: filt_r <= pwdata[15:0];
        `PSQ_PRG_LEN_OFS:
        begin
          prg_wsel_r <= pwdata[2:0];
          prg_start[pwdata[2:0]] <= prg_wptr_r;
          prg_len[pwdata[2:0]] <= 7'h00;
        end
        `PSQ_PRG_CMD_OFS:
        begin
          if (prg_wptr_r < `PSQ_MAX_STEPS)
          begin
            prg_wptr_r <= prg_wptr_r + 7'h01;
            prg_len[prg_wsel_r] <= prg_len[prg_wsel_r] + 7'h01;
          end
          else
            prg_err_r <= 1'b1;
        end
        default: ;
      endcase
    end
  end
  always @(posedge clock)
  begin
    if (rst_n && wr && paddr == `PSQ_TAB_POS_OFS)
      tab_pos[tab_idx_r] <= clamp(pwdata[23:0]);
    if (rst_n && wr && paddr == `PSQ_TAB_CFG_OFS)
      tab_cfg[tab_idx_r] <= pwdata[19:0];
    if (rst_n && wr && paddr == `PSQ_TAB_TC_OFS)
      tab_tc[tab_idx_r] <= pwdata;
    if (rst_n && wr && paddr == `PSQ_PRG_CMD_OFS && prg_wptr_r < `PSQ_MAX_STEPS)
      prg_mem[prg_wptr_r] <= pwdata;
  end
  wire [2:0] aux = tab_cfg[cur_tab_r][2:0];
  wire moving = state_r == ST_MOVE || state_r == ST_DECEL;
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      target_r <= 24'sd0;
      cur_r <= 24'sd0;
      speed_r <= 16'h0000;
      acc_r <= 16'h0000;
      dec_r <= 16'h0000;
      scurve_r <= 7'h00;
      cur_tab_r <= 3'h1;
      chain_len_r <= 3'h0;
      pc_r <= 7'h00;
      pend_r <= 7'h00;
      dir_rev_r <= 1'b0;
      div_r <= 16'h0000;
      move_complete_flag <= 1'b0;
      in_position_flag <= 1'b1;
      motion_active <= 1'b0;
      pause_active <= 1'b0;
    end
    else
    begin
      div_r <= (div_r >= STEP_DIV) ? 16'h0000 : div_r + 16'h0001;
      in_position_flag <= remain == 24'sd0;
      motion_active <= moving;
      pause_active <= state_r == ST_HALT;
      case (state_r)
        ST_IDLE:
        begin
          // starts only honoured in auto mode outside homing and jog
          if ((fwd_rise || rev_rise) && auto_on && !homing && !jogging)
          begin
            move_complete_flag <= 1'b0;
            dir_rev_r <= rev_rise;
            chain_len_r <= 3'h1;
            if (ctrl_r[`PSQ_CTRL_PRG] && fwd_rise)
            begin
              pc_r <= prg_start[prog_sel];
              pend_r <= prg_start[prog_sel] + prg_len[prog_sel];
              state_r <= ST_PSTEP;
            end
            else if (!ctrl_r[`PSQ_CTRL_PRG])
            begin
              cur_tab_r <= tab_idx_r;
              state_r <= ST_LOAD;
            end
          end
        end
        ST_LOAD:
        begin
          speed_r <= tab_cfg[cur_tab_r][19:4];
          acc_r <= tab_tc[cur_tab_r][15:0];
          dec_r <= tab_tc[cur_tab_r][31:16];
          if (tab_cfg[cur_tab_r][`PSQ_INC_BIT] || ctrl_r[`PSQ_CTRL_INCR])
            target_r <= clamp(target_r + (dir_rev_r ? -tab_pos[cur_tab_r] : tab_pos[cur_tab_r]));
          else
            target_r <= tab_pos[cur_tab_r];
          state_r <= ST_MOVE;
        end
        ST_PSTEP:
        begin
          if (pc_r == pend_r)
          begin
            state_r <= ST_IDLE;
            move_complete_flag <= 1'b1;
          end
          else
          begin
            pc_r <= pc_r + 7'h01;
            case (op[31:28])
              `PSQ_OP_SPEED: speed_r <= (operand[15:0] > MAX_SPEED) ? MAX_SPEED : operand[15:0];
              `PSQ_OP_ACC: acc_r <= tc_op;
              `PSQ_OP_DEC: dec_r <= tc_op;
              `PSQ_OP_ACCDEC:
              begin
                acc_r <= tc_op;
                dec_r <= tc_op;
              end
              `PSQ_OP_SCURVE:
                scurve_r <= (operand[6:0] > `PSQ_SCURVE_MAX) ? `PSQ_SCURVE_MAX : operand[6:0];
              `PSQ_OP_ABS, `PSQ_OP_ABS_CHAIN:
              begin
                target_r <= clamp(operand);
                state_r <= ST_MOVE;
              end
              `PSQ_OP_INC, `PSQ_OP_INC_CHAIN:
              begin
                target_r <= clamp(target_r + operand);
                state_r <= ST_MOVE;
              end
              default: ;
            endcase
          end
        end
        ST_MOVE, ST_DECEL:
        begin
          // pause only outside homing and jog
          if (pause_rise && !homing && !jogging && state_r == ST_MOVE)
            state_r <= ST_DECEL;
          else if (div_r == 16'h0000 && remain != 24'sd0)
            cur_r <= (remain > 0) ? cur_r + 24'sd1 : cur_r - 24'sd1;
          // halt when step divider reaches STEP_DIV
          else if (state_r == ST_DECEL && div_r == STEP_DIV)
            state_r <= ST_HALT;
          else if (remain == 24'sd0 && state_r == ST_MOVE)
          begin
            motion_active <= 1'b0;
            if (ctrl_r[`PSQ_CTRL_PRG])
              state_r <= ST_PSTEP;
            // chain on aux 1 or 3, seven max
            else if ((aux == 3'd1 || aux == 3'd3) && chain_len_r < `PSQ_MAX_TABLES
                     && cur_tab_r < 3'd7)
            begin
              cur_tab_r <= cur_tab_r + 3'd1;
              chain_len_r <= chain_len_r + 3'd1;
              state_r <= ST_LOAD;
            end
            else
            begin
              move_complete_flag <= 1'b1;
              state_r <= ST_IDLE;
            end
          end
        end
        ST_HALT:
        begin
          if (!auto_on)
          begin
            target_r <= cur_r;
            state_r <= ST_IDLE;
          end
          else if (pause_rise && !homing && !jogging)
            state_r <= ST_MOVE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= 1'b0;
      if (setup)
      begin
        prdata <= 32'h00000000;
        case (paddr)
          `PSQ_CTRL_OFS: prdata <= {29'h0, ctrl_r};
          `PSQ_STAT_OFS: prdata <= {21'h0, total_steps, prg_err_r, state_r};
          `PSQ_TAB_IDX_OFS: prdata <= {29'h0, tab_idx_r};
          `PSQ_TARGET_OFS: prdata <= {{8{target_r[23]}}, target_r};
          `PSQ_REMAIN_OFS: prdata <= {{8{remain[23]}}, remain};
          `PSQ_SPEED_OFS: prdata <= {16'h0, speed_r};
          `PSQ_TC_OFS: prdata <= {dec_r, acc_r};
          `PSQ_FILT_OFS: prdata <= {9'h0, scurve_r, filt_r};
          `PSQ_TAB_POS_OFS, `PSQ_TAB_CFG_OFS, `PSQ_TAB_TC_OFS, `PSQ_PRG_CMD_OFS,
          `PSQ_PRG_LEN_OFS: ;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule // psq_positioning_sequencer

//--- include/psq_defs.vh
`ifndef PSQ_DEFS_VH
`define PSQ_DEFS_VH
// apb register byte offsets
`define PSQ_CTRL_OFS 12'h000
`define PSQ_STAT_OFS 12'h004
`define PSQ_TAB_IDX_OFS 12'h008
`define PSQ_TAB_POS_OFS 12'h00c
`define PSQ_TAB_CFG_OFS 12'h010
`define PSQ_TAB_TC_OFS 12'h014
`define PSQ_PRG_CMD_OFS 12'h018
`define PSQ_TARGET_OFS 12'h01c
`define PSQ_REMAIN_OFS 12'h020
`define PSQ_SPEED_OFS 12'h024
`define PSQ_TC_OFS 12'h028
`define PSQ_PRG_LEN_OFS 12'h02c
`define PSQ_FILT_OFS 12'h030
// ctrl fields
`define PSQ_CTRL_AUTO 0
`define PSQ_CTRL_PRG 1
`define PSQ_CTRL_INCR 2
// table cfg fields: [2:0] aux code, [3] incremental, [19:4] speed
`define PSQ_AUX_LSB 0
`define PSQ_INC_BIT 3
`define PSQ_SPD_LSB 4
// program command opcodes in [31:28], operand in [23:0]
`define PSQ_OP_SPEED 4'h1
`define PSQ_OP_ACC 4'h2
`define PSQ_OP_DEC 4'h3
`define PSQ_OP_ACCDEC 4'h4
`define PSQ_OP_SCURVE 4'h5
`define PSQ_OP_ABS 4'h6
`define PSQ_OP_ABS_CHAIN 4'h7
`define PSQ_OP_INC 4'h8
`define PSQ_OP_INC_CHAIN 4'h9
// limits
`define PSQ_POS_MAX 24'sh0f423f
`define PSQ_TC_MAX 16'h4e20
`define PSQ_SCURVE_MAX 7'h64
`define PSQ_MAX_TABLES 7
`define PSQ_MAX_PROGS 8
`define PSQ_MAX_STEPS 120
`define PSQ_RATED_RPM 3000
`define PSQ_FILT_RESET 16'h0010
`endif

//--- verif/psq_asserts.sv
`timescale 1ns/100ps
module psq_asserts (
  input wire clock,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire home_active,
  input wire jog_active,
  input wire move_complete_flag,
  input wire in_position_flag,
  input wire motion_active,
  input wire pause_active
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  a_ready_access: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_err: assert property (psel && penable && pready && paddr > 12'h030 |-> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && penable && pready && paddr <= 12'h030 |-> !pslverr)
    else $error("mapped access refused");
  a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside setup");
  a_chain_no_done: assert property (motion_active |-> !move_complete_flag)
    else $error("complete flag while moving");
  a_moving_not_inpos: assert property (motion_active ##1 motion_active |-> !in_position_flag)
    else $error("in position while moving");
  a_pause_blocked: assert property ($rose(pause_active) |-> !home_active && !jog_active)
    else $error("pause taken during home or jog");
  c_err: cover property (pslverr);
  c_pause: cover property ($rose(pause_active));
  c_done: cover property ($rose(move_complete_flag));
endmodule // psq_asserts

bind psq_positioning_sequencer psq_asserts i_chk (
  .clock(clock),
  .resetn(resetn),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .home_active(home_active),
  .jog_active(jog_active),
  .move_complete_flag(move_complete_flag),
  .in_position_flag(in_position_flag),
  .motion_active(motion_active),
  .pause_active(pause_active)
);

//--- verif/psq_host_model.sv
`timescale 1ns/100ps
module psq_host_model (
  input wire clock,
  output logic pause_request,
  output logic forward_start,
  output logic reverse_start,
  output logic program_select_0,
  output logic program_select_1,
  output logic program_select_2
);
  initial {pause_request, forward_start, reverse_start} = 3'h0;
  initial {program_select_2, program_select_1, program_select_0} = 3'h0;
  task pulse(input int k);
    @(posedge clock);
    pause_request <= (k == 0);
    forward_start <= (k == 1);
    reverse_start <= (k == 2);
    repeat (24) @(posedge clock);
    {pause_request, forward_start, reverse_start} <= 3'h0;
    repeat (24) @(posedge clock);
  endtask
  task go(input logic [2:0] s);
    @(posedge clock);
    {program_select_2, program_select_1, program_select_0} <= s;
    repeat (24) @(posedge clock);
    pulse(1);
  endtask
endmodule // psq_host_model

//--- verif/tb_positioning_sequencer.sv
`timescale 1ns/100ps
`include "psq_defs.vh"
module tb_positioning_sequencer;
  logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic home_active = 0, jog_active = 0, auto_mode = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, sd = 32'h3f;
  wire [31:0] prdata;
  wire pready, pslverr, pz, fs, rs, ps0, ps1, ps2, mc, ip, ma, pa;
  int err_total = 0, checks_done = 0, a, d, t = 0, i, r;
  initial forever #2.5 clock = ~clock;
  psq_positioning_sequencer #(.STEP_DIV(16'd4)) i_dut (.clock(clock), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pause_request(pz),
    .forward_start(fs), .reverse_start(rs), .program_select_0(ps0),
    .program_select_1(ps1), .program_select_2(ps2), .home_active(home_active),
    .jog_active(jog_active), .auto_mode(auto_mode), .move_complete_flag(mc),
    .in_position_flag(ip), .motion_active(ma), .pause_active(pa));
  psq_host_model i_host (.clock(clock), .pause_request(pz), .forward_start(fs),
    .reverse_start(rs), .program_select_0(ps0), .program_select_1(ps1),
    .program_select_2(ps2));
  function automatic logic [31:0] rnd();
    sd ^= sd << 13;
    sd ^= sd >> 17;
    sd ^= sd << 5;
    return sd;
  endfunction
  function automatic int nxt(input int pv, input int p, input bit inc);
    return inc ? pv + p : p;
  endfunction
  task print_verdict();
    if (err_total == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task bail(input int n);
    if (n >= 4000)
    begin
      err_total++;
      print_verdict();
    end
  endtask
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    @(posedge clock);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 4000);
    rd = prdata;
    err = pslverr;
    bail(n);
    psel <= 0;
    penable <= 0;
  endtask
  task wait_mc(input logic v);
    int n;
    n = 0;
    while (mc !== v && n < 4000)
    begin
      @(posedge clock);
      n++;
    end
    bail(n);
  endtask
  task load(input int n, input int p, input logic [31:0] cfg);
    apb(1, `PSQ_TAB_IDX_OFS, n);
    apb(1, `PSQ_TAB_POS_OFS, p);
    apb(1, `PSQ_TAB_CFG_OFS, cfg);
    apb(1, `PSQ_TAB_TC_OFS, {16'd50, 16'd100});
  endtask
  task run(input logic [2:0] s);
    i_host.go(s);
    wait_mc(1);
    apb(0, `PSQ_TARGET_OFS, 0);
  endtask
  initial
  begin
    repeat (8) @(posedge clock);
    resetn <= 1;
    repeat (4) @(posedge clock);
    chk("complete_rst", 32'h0, {31'h0, mc});
    chk("inpos_rst", 32'h1, {31'h0, ip});
    apb(0, `PSQ_CTRL_OFS, 0);
    chk("incr_mode", 32'h0, {31'h0, rd[`PSQ_CTRL_INCR]});
    apb(0, 12'h100, 0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    apb(1, `PSQ_CTRL_OFS, 1);
    repeat (3)
    begin
      a = rnd() % 16 + 1;
      d = rnd() % 8 + 1;
      r = rnd() % 2;
      load(1, a, r ? 32'h64b : 32'h641);
      load(2, d, 32'h64a);
      apb(1, `PSQ_TAB_IDX_OFS, 1);
      run(1);
      t = nxt(nxt(t, a, r), d, 1);
      chk("chain_target", t, rd);
    end
    load(3, -100, 32'h640);
    i_host.go(3);
    i_host.pulse(0);
    chk("paused", 32'h1, {31'h0, pa});
    i_host.pulse(1);
    i_host.pulse(2);
    chk("start_ignored", 32'h1, {31'h0, pa});
    i_host.pulse(0);
    wait_mc(1);
    apb(0, `PSQ_TARGET_OFS, 0);
    chk("resume_target", -100, rd);
    apb(0, `PSQ_REMAIN_OFS, 0);
    chk("resume_remain", 32'h0, rd);
    load(4, 200, 32'h640);
    i_host.go(4);
    for (i = 0; i < 2; i++)
    begin
      home_active <= (i == 0);
      jog_active <= (i == 1);
      repeat (24) @(posedge clock);
      i_host.pulse(0);
      chk("pause_blocked", 32'h0, {31'h0, pa});
    end
    jog_active <= 0;
    repeat (24) @(posedge clock);
    i_host.pulse(0);
    chk("paused_move", 32'h1, {31'h0, pa});
    auto_mode <= 0;
    repeat (4) @(posedge clock);
    apb(0, `PSQ_REMAIN_OFS, 0);
    chk("manual_remain", 32'h0, rd);
    chk("manual_unpaused", 32'h0, {31'h0, pa});
    auto_mode <= 1;
    a = rnd() % 8;
    apb(1, `PSQ_PRG_LEN_OFS, a);
    apb(1, `PSQ_PRG_CMD_OFS, {`PSQ_OP_SPEED, 4'h0, 24'd100});
    apb(1, `PSQ_PRG_CMD_OFS, {`PSQ_OP_ABS, 4'h0, 24'd12});
    apb(1, `PSQ_PRG_CMD_OFS, {`PSQ_OP_INC, 4'h0, 24'd3});
    apb(0, `PSQ_STAT_OFS, 0);
    chk("prog_steps", 32'h3, {25'h0, rd[10:4]});
    apb(1, `PSQ_CTRL_OFS, 3);
    run(a[2:0]);
    chk("prog_target", nxt(12, 3, 1), rd);
    print_verdict();
  end
endmodule // tb_positioning_sequencer
